// ==== shared/xbd_pkg.sv ====
// Package for the extension bus decoder: register map, field positions,
// address windows and the packed carriers shared by design and bench.
// Assumes a 24-bit CPU byte address and a 32-bit APB register port.
package xbd_pkg;

  // ----------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------
  localparam logic [7:0] ADDR_SYS_CONFIG  = 8'h00;  // system_config_reg
  localparam logic [7:0] ADDR_PERIPH_EN   = 8'h04;  // bus_peripheral_enable
  localparam logic [7:0] ADDR_RAM_WINDOW  = 8'h08;  // ram_window_select
  localparam logic [7:0] ADDR_STATUS      = 8'h0C;  // read-only state

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int          GLOBAL_EN_BIT     = 2;
  localparam int          EN_CAN1           = 0;
  localparam int          EN_CAN2           = 1;
  localparam int          EN_RAM1           = 2;
  localparam int          EN_RAM2           = 3;
  localparam int          EN_RTC            = 4;
  localparam int          EN_PWM            = 6;
  localparam int          EN_ASC            = 7;
  localparam int          EN_SSC            = 8;
  localparam int          EN_I2C            = 9;
  localparam int          EN_MISC           = 10;
  localparam logic [15:0] SYS_CONFIG_RESET  = 16'h0000;
  localparam logic [15:0] PERIPH_EN_RESET   = 16'h0000;
  localparam logic [15:0] RAM_WINDOW_RESET  = 16'h0F09;  // Low segment 09h, high segment 0Fh.
  localparam logic [15:0] PERIPH_EN_MASK    = 16'h07DF;  // Bits that exist.

  // ----------------------------------------
  // Address windows
  // ----------------------------------------
  localparam logic [23:0] FLASH_LO_END      = 24'h00_7FFF;
  localparam logic [23:0] FLASH_HI_START    = 24'h01_8000;
  localparam logic [23:0] FLASH_HI_END      = 24'h04_FFFF;
  localparam logic [23:0] TEST_FLASH_END    = 24'h00_0FFF;
  localparam logic [23:0] RAM1_START        = 24'h00_E000;
  localparam logic [23:0] RAM1_END          = 24'h00_E7FF;
  localparam logic [15:0] PAGE_SSC          = 16'h00E8;
  localparam logic [15:0] PAGE_ASC          = 16'h00E9;
  localparam logic [15:0] PAGE_I2C          = 16'h00EA;
  localparam logic [15:0] PAGE_MISC         = 16'h00EB;
  localparam logic [15:0] PAGE_PWM          = 16'h00EC;
  localparam logic [15:0] PAGE_RTC          = 16'h00ED;
  localparam logic [15:0] PAGE_CAN2         = 16'h00EE;
  localparam logic [15:0] PAGE_CAN1         = 16'h00EF;

  // ----------------------------------------
  // Timing and bus characteristics
  // ----------------------------------------
  localparam logic [1:0]  PERIPH_WAITS      = 2'h2;
  localparam logic [1:0]  RAM_WAITS         = 2'h0;
  localparam logic [3:0]  SEG_LINES_FULL    = 4'h8;
  localparam logic [3:0]  SEG_LINES_CAN     = 4'h4;

  // Target index in the one-hot select vector.
  localparam int TGT_FLASH = 0;
  localparam int TGT_TFLASH = 1;
  localparam int TGT_RAM1 = 2;
  localparam int TGT_RAM2 = 3;
  localparam int TGT_CAN1 = 4;
  localparam int TGT_CAN2 = 5;
  localparam int TGT_RTC = 6;
  localparam int TGT_PWM = 7;
  localparam int TGT_ASC = 8;
  localparam int TGT_SSC = 9;
  localparam int TGT_I2C = 10;
  localparam int TGT_MISC = 11;
  localparam int TGT_EXT = 12;
  localparam int TGT_N = 13;

  // CPU access request.
  typedef struct packed {
    logic        valid;   // Access present this cycle.
    logic        byte_sz; // Byte transfer when high, word otherwise.
    logic [23:0] addr;    // Byte address.
  } xbd_req_t;

  // Decode result handed to the targets.
  typedef struct packed {
    logic              valid;     // Decode is live.
    logic [TGT_N-1:0]  sel;       // One-hot target.
    logic [1:0]        waits;     // Wait states for the access.
    logic              demux16;   // 16-bit demultiplexed access.
    logic              word_only; // Target accepts words only.
    logic              size_err;  // Byte access to a word-only target.
    logic [13:0]       ram2_off;  // Offset inside the mirrored RAM window.
  } xbd_dec_t;

endpackage

// ==== verilog/xbd_decoder.sv ====
// Address decoder and select logic for the on-chip extension bus.
// Assumes CPU requests, the soft reset request and the end-of-init pulse
// are on clk_i; only the boot mode strap comes from a pin.
//
// How it works
// RL1 - 24-bit byte or word address space.
// RL2 - User mode maps eight flash blocks.
// RL3 - Bootstrap shows test flash at zero.
// RL4 - RAM1 needs global and bit 2.
// RL5 - Disabled RAM1 range goes external.
// RL6 - RAM2 at window needs global, bit 3.
// RL7 - Global off sends RAM2 range external.
// RL8 - RAM2 resets to 09h, mirrored to 0Fh.
// RL9 - RAM: 16-bit, no waits, any size.
// RL10 - CAN1 page EFh with bit 0.
// RL11 - CAN2 page EEh with bit 1.
// RL12 - RTC page EDh with bit 4.
// RL13 - PWM page ECh with bit 6.
// RL14 - Async serial page E9h, bit 7.
// RL15 - Sync serial page E8h, bit 8.
// RL16 - I2C page EAh with bit 9.
// RL17 - Misc block page EBh, bit 10.
// RL18 - Peripherals: words only, two waits.
// RL19 - CAN in use limits segment lines.
// RL20 - Disabled peripheral occupies nothing.
// RL21 - After end-of-init, gate unused clocks.
// RL22 - No reset to gated peripherals.
// RL23 - Enables evaluated fresh every access.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module xbd_decoder
  import xbd_pkg::*;
(
  input  wire logic              clk_i,          // CPU clock.
  input  wire logic              rst_n_i,        // Asynchronous reset, active low.
  // APB register port.
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // CPU side.
  input  wire xbd_req_t          cpu_req_i,      // Access request.
  input  wire logic              boot_mode_i,    // Bootstrap strap pin.
  input  wire logic              end_init_i,     // One-cycle end-of-init pulse.
  input  wire logic              soft_rst_req_i, // Peripheral reset request pulse.
  // Target side.
  output xbd_dec_t               dec_o,          // Registered decode.
  output logic      [TGT_N-1:0]  clk_en_o,       // Per-target clock enable.
  output logic      [TGT_N-1:0]  periph_rst_n_o, // Per-target reset, active low.
  output logic      [3:0]        seg_lines_o     // Usable segment address lines.
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [15:0] sys_config;        // Holds the global enable.
  logic [15:0] periph_en;         // Per-module enable bits.
  logic [15:0] ram_window;        // RAM2 low/high segment.
  logic        init_done;         // End of init has happened.
  logic        boot_meta;         // Strap synchroniser stage one.
  logic        boot_sync;         // Strap synchroniser stage two.
  logic        boot_mode;         // Mode caught after reset release.
  logic        boot_caught;       // Strap has been caught.
  logic [1:0]  boot_age;          // Marks that both strap flops hold real samples.
  xbd_dec_t    next_dec;          // Combinational decode.
  logic [TGT_N-1:0] next_clk_en;  // Combinational clock enables.

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic apb_setup;
  logic apb_done;
  logic apb_mapped;

  assign apb_setup  = psel_i & ~penable_i;
  assign apb_done   = psel_i & penable_i & pready_o;
  assign apb_mapped = (paddr_i == ADDR_SYS_CONFIG) || (paddr_i == ADDR_PERIPH_EN) ||
                      (paddr_i == ADDR_RAM_WINDOW) || (paddr_i == ADDR_STATUS);

  // Ready rises one cycle into the access phase and drops after the
  // handshake, so every transfer has exactly one wait cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
    end
  end

  // Read data and the error answer are prepared in the setup cycle,
  // which keeps both outputs straight from flops.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (apb_setup) begin
      pslverr_o <= ~apb_mapped;
      case (paddr_i)
        ADDR_SYS_CONFIG: begin
          prdata_o <= {16'h0000, sys_config};
        end
        ADDR_PERIPH_EN: begin
          prdata_o <= {16'h0000, periph_en};
        end
        ADDR_RAM_WINDOW: begin
          prdata_o <= {16'h0000, ram_window};
        end
        ADDR_STATUS: begin
          // Init state, boot mode and CAN-in-use for software to see.
          prdata_o <= {28'h000_0000, seg_lines_o == SEG_LINES_CAN, boot_mode, 1'b0, init_done};
        end
        default: begin
          prdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Configuration writes land at the handshake edge only.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sys_config <= SYS_CONFIG_RESET;
      periph_en  <= PERIPH_EN_RESET;
      ram_window <= RAM_WINDOW_RESET; // RL8
    end else if (apb_done && pwrite_i) begin
      case (paddr_i)
        ADDR_SYS_CONFIG: begin
          sys_config <= pwdata_i[15:0];
        end
        ADDR_PERIPH_EN: begin
          periph_en <= pwdata_i[15:0] & PERIPH_EN_MASK;
        end
        ADDR_RAM_WINDOW: begin
          ram_window <= pwdata_i[15:0];
        end
        default: begin
          sys_config <= sys_config;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Boot strap and end of init
  // ----------------------------------------
  // The strap is a pin, so it passes two flops before use.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_meta <= 1'b0;
      boot_sync <= 1'b0;
    end else begin
      boot_meta <= boot_mode_i;
      boot_sync <= boot_meta;
    end
  end

  // Both strap flops hold reset values at release, so the catch waits
  // until a real sample has reached the second stage.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_age <= 2'b00;
    end else begin
      boot_age <= {boot_age[0], 1'b1};
    end
  end

  // The mode is caught once after reset and then held, so a strap that
  // later changes cannot remap flash under running code.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_mode   <= 1'b0;
      boot_caught <= 1'b0;
    end else if (boot_age[1] && !boot_caught) begin
      boot_mode   <= boot_sync;
      boot_caught <= 1'b1;
    end
  end

  // End of init is sticky until the next system reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_done <= 1'b0;
    end else if (end_init_i) begin
      init_done <= 1'b1;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic        gen;       // Global enable.
  logic [15:0] page;      // Address bits 23:8.
  logic [7:0]  seg;       // Address bits 23:16.
  logic        in_ram2;   // Inside the programmed RAM2 segments.

  assign gen  = sys_config[GLOBAL_EN_BIT];
  assign page = cpu_req_i.addr[23:8];
  assign seg  = cpu_req_i.addr[23:16];
  // The window spans whole segments and the 16K RAM repeats in each.
  assign in_ram2 = (seg >= ram_window[7:0]) && (seg <= ram_window[15:8]);

  // Enables are read fresh for every access, so a write is seen by the
  // next request without any resync step.
  always_comb begin // RL23
    next_dec          = '0;
    next_dec.valid    = cpu_req_i.valid;
    next_dec.ram2_off = cpu_req_i.addr[13:0];
    next_dec.demux16  = 1'b1;
    if (boot_mode && (cpu_req_i.addr <= TEST_FLASH_END)) begin
      next_dec.sel[TGT_TFLASH] = 1'b1; // RL3
      next_dec.demux16         = 1'b0;
    end else if (cpu_req_i.addr <= FLASH_LO_END) begin
      next_dec.sel[TGT_FLASH] = 1'b1; // RL2
      next_dec.demux16        = 1'b0;
    end else if ((cpu_req_i.addr >= FLASH_HI_START) && (cpu_req_i.addr <= FLASH_HI_END)) begin
      next_dec.sel[TGT_FLASH] = 1'b1; // RL2
      next_dec.demux16        = 1'b0;
    end else if ((cpu_req_i.addr >= RAM1_START) && (cpu_req_i.addr <= RAM1_END)) begin
      if (gen && periph_en[EN_RAM1]) begin
        next_dec.sel[TGT_RAM1] = 1'b1; // RL4
        next_dec.waits         = RAM_WAITS; // RL9
      end else begin
        next_dec.sel[TGT_EXT] = 1'b1; // RL5
      end
    end else if (in_ram2 && gen) begin
      if (periph_en[EN_RAM2]) begin
        next_dec.sel[TGT_RAM2] = 1'b1; // RL6
        next_dec.waits         = RAM_WAITS; // RL9
      end else begin
        next_dec.sel[TGT_EXT] = 1'b1;
      end
    end else if (in_ram2) begin
      next_dec.sel[TGT_EXT] = 1'b1; // RL7
    end else begin
      // Peripheral pages; a disabled one falls through to external. RL20
      next_dec.word_only = gen;
      next_dec.waits     = gen ? PERIPH_WAITS : 2'h0; // RL18
      case (page)
        PAGE_CAN1: begin
          next_dec.sel[TGT_CAN1] = gen && periph_en[EN_CAN1]; // RL10
        end
        PAGE_CAN2: begin
          next_dec.sel[TGT_CAN2] = gen && periph_en[EN_CAN2]; // RL11
        end
        PAGE_RTC: begin
          next_dec.sel[TGT_RTC] = gen && periph_en[EN_RTC]; // RL12
        end
        PAGE_PWM: begin
          next_dec.sel[TGT_PWM] = gen && periph_en[EN_PWM]; // RL13
        end
        PAGE_ASC: begin
          next_dec.sel[TGT_ASC] = gen && periph_en[EN_ASC]; // RL14
        end
        PAGE_SSC: begin
          next_dec.sel[TGT_SSC] = gen && periph_en[EN_SSC]; // RL15
        end
        PAGE_I2C: begin
          next_dec.sel[TGT_I2C] = gen && periph_en[EN_I2C]; // RL16
        end
        PAGE_MISC: begin
          next_dec.sel[TGT_MISC] = gen && periph_en[EN_MISC]; // RL17
        end
        default: begin
          // Left unclaimed so the fix-up below also clears the timing.
          next_dec.sel = '0;
        end
      endcase
      if (next_dec.sel == '0) begin
        // Nothing claimed the page: it belongs to the external bus. RL20
        next_dec.sel[TGT_EXT] = 1'b1;
        next_dec.word_only    = 1'b0;
        next_dec.waits        = 2'h0;
      end
    end
    // Word-only targets refuse byte transfers; RAM takes both. RL18
    next_dec.size_err = next_dec.word_only & cpu_req_i.byte_sz & cpu_req_i.valid; // RL1
    if (!cpu_req_i.valid) begin
      next_dec.sel = '0;
    end
  end

  // Decode is registered so the targets see it one cycle after the request.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_o <= '0;
    end else begin
      dec_o <= next_dec;
    end
  end

  // ----------------------------------------
  // Clock gating and peripheral reset
  // ----------------------------------------
  // Before end of init every clock runs so software can still set up;
  // afterwards only enabled peripherals keep one. RAMs, misc and the
  // non-bus targets are never gated.
  always_comb begin
    next_clk_en            = {TGT_N{1'b1}};
    next_clk_en[TGT_CAN1]  = !init_done || periph_en[EN_CAN1]; // RL21
    next_clk_en[TGT_CAN2]  = !init_done || periph_en[EN_CAN2]; // RL21
    next_clk_en[TGT_RTC]   = !init_done || periph_en[EN_RTC]; // RL21
    next_clk_en[TGT_PWM]   = !init_done || periph_en[EN_PWM]; // RL21
    next_clk_en[TGT_ASC]   = !init_done || periph_en[EN_ASC]; // RL21
    next_clk_en[TGT_SSC]   = !init_done || periph_en[EN_SSC]; // RL21
    next_clk_en[TGT_I2C]   = !init_done || periph_en[EN_I2C]; // RL21
  end

  // Clock enables are flopped; a gate cell downstream uses them.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_en_o <= {TGT_N{1'b1}};
    end else begin
      clk_en_o <= next_clk_en;
    end
  end

  // A soft reset request reaches only clocked targets; a gated one would
  // never see the edge anyway and must stay quiet.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periph_rst_n_o <= {TGT_N{1'b0}};
    end else begin
      periph_rst_n_o <= ~({TGT_N{soft_rst_req_i}} & next_clk_en); // RL22
    end
  end

  // CAN use claims port pins, leaving only four segment lines.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seg_lines_o <= SEG_LINES_FULL;
    end else if (gen && (periph_en[EN_CAN1] || periph_en[EN_CAN2])) begin
      seg_lines_o <= SEG_LINES_CAN; // RL19
    end else begin
      seg_lines_o <= SEG_LINES_FULL;
    end
  end

endmodule

// ==== tb/xbd_decoder_checker.sv ====
// Checker for the extension bus decoder, bound to its top module.
// Assumes single-cycle end-of-init pulses and APB writes on clk_i.
`timescale 1ns/1ps
module xbd_decoder_checker
  import xbd_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic             pwrite_i,
  input wire logic [7:0]       paddr_i,
  input wire logic [31:0]      pwdata_i,
  input wire logic             pready_o,
  input wire xbd_req_t         cpu_req_i,
  input wire logic             end_init_i,
  input wire logic             soft_rst_req_i,
  input wire xbd_dec_t         dec_o,
  input wire logic [TGT_N-1:0] clk_en_o,
  input wire logic [TGT_N-1:0] periph_rst_n_o,
  input wire logic [3:0]       seg_lines_o
);
  // ----
  // Shadow of the configuration, updated at the completing APB edge.
  // ----
  logic        gen;    // Global enable copy.
  logic [15:0] pen;    // Peripheral enable copy.
  logic [15:0] win;    // RAM window copy.
  logic        init;   // End of init seen.
  logic        wr;     // Write completes this edge.
  logic [7:0]  sg;     // Request segment.
  logic [13:0] lo;     // Request offset inside 16K.
  logic        in_win; // Request inside the RAM window.
  logic        valid;  // Request present.
  assign wr = psel_i & penable_i & pready_o & pwrite_i;
  assign sg = cpu_req_i.addr[23:16];
  assign lo = cpu_req_i.addr[13:0];
  assign valid = cpu_req_i.valid;
  // Segments up to 04h belong to flash and the low pages, so they are left out.
  assign in_win = valid && sg > 8'h04 && sg >= win[7:0] && sg <= win[15:8];
  // Copies of the registers that drive decoding.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen <= SYS_CONFIG_RESET[GLOBAL_EN_BIT];
      pen <= PERIPH_EN_RESET;
      win <= RAM_WINDOW_RESET;
    end else if (wr) begin
      if (paddr_i == ADDR_SYS_CONFIG) gen <= pwdata_i[GLOBAL_EN_BIT];
      if (paddr_i == ADDR_PERIPH_EN) pen <= pwdata_i[15:0] & PERIPH_EN_MASK;
      if (paddr_i == ADDR_RAM_WINDOW) win <= pwdata_i[15:0];
    end
  end
  // End of init is sticky until reset.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) init <= 1'b0;
    else if (end_init_i) init <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_IDLE: assert property (!valid |=> dec_o.sel == '0)
    else $error("decode live without request");
  AST_FLASH: assert property (valid && cpu_req_i.addr >= 24'h01_8000 && cpu_req_i.addr <= 24'h04_FFFF
    |=> dec_o.sel[TGT_FLASH]) else $error("upper flash not selected");
  AST_RAM1: assert property (valid && cpu_req_i.addr[23:11] == 13'h001C && gen && pen[2]
    |=> dec_o.sel[TGT_RAM1]) else $error("first RAM not selected");
  AST_RAM1_EXT: assert property (valid && cpu_req_i.addr[23:11] == 13'h001C && !(gen && pen[2])
    |=> dec_o.sel[TGT_EXT]) else $error("first RAM range not external");
  AST_RAM2: assert property (in_win && gen && pen[3]
    |=> dec_o.sel[TGT_RAM2] && dec_o.ram2_off == $past(lo)) else $error("second RAM miss");
  AST_RAM2_EXT: assert property (in_win && !gen |=> dec_o.sel[TGT_EXT])
    else $error("second RAM range not external");
  AST_RAM_TIM: assert property (dec_o.sel[TGT_RAM1] || dec_o.sel[TGT_RAM2]
    |-> dec_o.waits == 2'h0 && dec_o.demux16 && !dec_o.size_err) else $error("RAM timing");
  AST_CAN1: assert property (valid && cpu_req_i.addr[23:8] == 16'h00EF && gen && pen[0]
    |=> dec_o.sel[TGT_CAN1]) else $error("CAN1 not selected");
  AST_OFF: assert property (valid && cpu_req_i.addr[23:8] == 16'h00EF && gen && !pen[0]
    |=> !dec_o.sel[TGT_CAN1]) else $error("disabled CAN1 selected");
  AST_PER_TIM: assert property (|dec_o.sel[TGT_MISC:TGT_CAN1]
    |-> dec_o.waits == 2'h2 && dec_o.word_only && dec_o.demux16) else $error("peripheral timing");
  AST_SEG: assert property (gen && (pen[0] || pen[1]) |=> seg_lines_o == 4'h4)
    else $error("segment lines not limited");
  AST_GATE: assert property (init && !pen[1] |=> !clk_en_o[TGT_CAN2])
    else $error("disabled CAN2 still clocked");
  AST_KEEP: assert property (clk_en_o[TGT_RAM1] && clk_en_o[TGT_RAM2] && clk_en_o[TGT_MISC])
    else $error("RAM or misc clock stopped");
  AST_NORST: assert property (soft_rst_req_i && $past(init) && !pen[1] && $stable(pen)
    |=> periph_rst_n_o[TGT_CAN2]) else $error("reset sent to gated CAN2");
endmodule

// ==== tb/xbd_cpu_model.sv ====
// CPU core model issuing one access at a time.
// Assumes the decoder samples the request at every rising edge.
`timescale 1ns/1ps
module xbd_cpu_model
  import xbd_pkg::*;
(
  input  wire logic clk_i,
  output xbd_req_t  req_o
);
  initial req_o = '0;
  // Held for one edge; afterwards the address is inverted so a stale
  // value can never pass for a fresh one.
  task automatic access(input logic [23:0] a, input logic b);
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, byte_sz: b, addr: a};
    @(posedge clk_i);
    req_o <= '{valid: 1'b0, byte_sz: ~b, addr: ~a};
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the extension bus decoder.
// Assumes a 20 MHz clock and an APB slave with one wait cycle.
`timescale 1ns/1ps
module testbench;
  import xbd_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0000_0000;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  xbd_req_t         cpu_req;
  logic             boot = 1'b0;
  logic             end_init = 1'b0;
  logic             soft_rst = 1'b0;
  xbd_dec_t         dec;
  logic [TGT_N-1:0] clk_en;
  logic [TGT_N-1:0] prst_n;
  logic [3:0]       seg;
  int               n_errors = 0;
  int               cmp_count = 0;
  // Peripheral pages, enable bits and targets in one table.
  logic [15:0] pg [8] = '{16'h00EF, 16'h00EE, 16'h00ED, 16'h00EC, 16'h00E9, 16'h00E8, 16'h00EA, 16'h00EB};
  int          bt [8] = '{0, 1, 4, 6, 7, 8, 9, 10};
  int          tg [8] = '{TGT_CAN1, TGT_CAN2, TGT_RTC, TGT_PWM, TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC};
  always #25 clk_i = ~clk_i;
  xbd_decoder DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cpu_req_i(cpu_req), .boot_mode_i(boot), .end_init_i(end_init),
    .soft_rst_req_i(soft_rst), .dec_o(dec), .clk_en_o(clk_en), .periph_rst_n_o(prst_n), .seg_lines_o(seg));
  xbd_cpu_model u_cpu (.clk_i(clk_i), .req_o(cpu_req));
  // ----
  // Shared tasks.
  // ----
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk_val(r, x);
    chk_val({31'h0, e}, {31'h0, xe});
  endtask
  // One CPU access and a check of the one-hot target it selects.
  task automatic acc(input logic [23:0] a, input logic b, input int t);
    u_cpu.access(a, b);
    #1;
    chk_val({19'h0, dec.sel}, 32'h1 << t);
  endtask
  task automatic do_reset(input logic b);
    boot <= b;
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // ----
  // Scenarios.
  // ----
  task automatic t_regs();
    rd(ADDR_PERIPH_EN, 32'h0000_0000, 1'b0);
    rd(ADDR_RAM_WINDOW, 32'h0000_0F09, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    wr(ADDR_PERIPH_EN, 32'hFFFF_FFFF);
    rd(ADDR_PERIPH_EN, 32'h0000_07DF, 1'b0);
  endtask
  task automatic t_flash();
    acc(24'h00_7FFF, 1'b0, TGT_FLASH);
    acc(24'h01_8000, 1'b1, TGT_FLASH);
    acc(24'h04_FFFF, 1'b0, TGT_FLASH);
    acc(24'h05_0000, 1'b0, TGT_EXT);
  endtask
  task automatic t_periph();
    wr(ADDR_SYS_CONFIG, 32'h0000_0004);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_PERIPH_EN, 32'h0000_0000);
      acc({pg[i], 8'h10}, 1'b0, TGT_EXT);
      wr(ADDR_PERIPH_EN, 32'h1 << bt[i]);
      acc({pg[i], 8'hFE}, 1'b0, tg[i]);
      chk_val({30'h0, dec.waits}, 32'h0000_0002);
      acc({pg[i], 8'h01}, 1'b1, tg[i]);
      chk_val({31'h0, dec.size_err}, 32'h0000_0001);
      chk_val({28'h0, seg}, (i < 2) ? 32'h0000_0004 : 32'h0000_0008);
    end
    wr(ADDR_SYS_CONFIG, 32'h0000_0000);
    acc(24'h00_EB00, 1'b0, TGT_EXT);
  endtask
  task automatic t_ram();
    wr(ADDR_SYS_CONFIG, 32'h0000_0004);
    wr(ADDR_PERIPH_EN, 32'h0000_000C);
    acc(24'h00_E7FF, 1'b1, TGT_RAM1);
    acc(24'h0F_3FFE, 1'b0, TGT_RAM2);
    chk_val({18'h0, dec.ram2_off}, 32'h0000_3FFE);
    acc(24'h09_0001, 1'b1, TGT_RAM2);
    wr(ADDR_PERIPH_EN, 32'h0000_0008);
    acc(24'h00_E000, 1'b0, TGT_EXT);
    wr(ADDR_RAM_WINDOW, 32'h0000_0A0A);
    acc(24'h09_0000, 1'b0, TGT_EXT);
    acc(24'h0A_1234, 1'b0, TGT_RAM2);
    wr(ADDR_SYS_CONFIG, 32'h0000_0000);
    acc(24'h0A_1234, 1'b0, TGT_EXT);
  endtask
  task automatic t_gate();
    logic [TGT_N-1:0] e;
    e = '1;
    for (int i = 1; i < 7; i++) e[tg[i]] = 1'b0;
    chk_val({19'h0, clk_en}, {19'h0, {TGT_N{1'b1}}});
    wr(ADDR_PERIPH_EN, 32'h0000_0001);
    @(posedge clk_i);
    end_init <= 1'b1;
    @(posedge clk_i);
    end_init <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk_val({19'h0, clk_en}, {19'h0, e});
    @(posedge clk_i);
    soft_rst <= 1'b1;
    @(posedge clk_i);
    soft_rst <= 1'b0;
    #1;
    chk_val({19'h0, prst_n}, {19'h0, ~e});
  endtask
  task automatic t_boot();
    do_reset(1'b1);
    acc(24'h00_0100, 1'b0, TGT_TFLASH);
    acc(24'h00_1000, 1'b0, TGT_FLASH);
    rd(ADDR_STATUS, 32'h0000_0004, 1'b0);
  endtask
  task automatic end_of_test();
    $display("TB: errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #(50 * 5000);
    n_errors++;
    end_of_test();
  end
  initial begin
    do_reset(1'b0);
    t_regs();
    t_flash();
    t_periph();
    t_ram();
    t_gate();
    t_boot();
    end_of_test();
  end
endmodule
bind xbd_decoder xbd_decoder_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .cpu_req_i(cpu_req_i), .end_init_i(end_init_i), .soft_rst_req_i(soft_rst_req_i), .dec_o(dec_o),
  .clk_en_o(clk_en_o), .periph_rst_n_o(periph_rst_n_o), .seg_lines_o(seg_lines_o));
